// ### src/sltcs_defs.svh
// Offsets, field positions, reset values and codes of the link register bank
`ifndef SLTCS_DEFS_SVH
`define SLTCS_DEFS_SVH
// ==========================================
// Register offsets
`define SLTCS_OFS_IF_EN 12'h200
`define SLTCS_OFS_SW_SYNC 12'h203
`define SLTCS_OFS_CTRL 12'h204
`define SLTCS_OFS_TPAT 12'h205
`define SLTCS_OFS_ID 12'h206
`define SLTCS_OFS_COMMA 12'h207
`define SLTCS_OFS_STAT 12'h208
// ==========================================
// Reset values
`define SLTCS_RST_IF_EN 1'h1
`define SLTCS_RST_SW_SYNC 1'h1
`define SLTCS_RST_CTRL 4'h2
`define SLTCS_RST_TPAT 4'h0
`define SLTCS_RST_ID 8'h00
`define SLTCS_RST_COMMA 2'h0
// ==========================================
// Status field positions
`define SLTCS_ST_LINK 6
`define SLTCS_ST_SYNC 5
`define SLTCS_ST_REALIGN 4
`define SLTCS_ST_ALIGN 3
`define SLTCS_ST_PLL 2
// ==========================================
// Sync source codes
`define SLTCS_SYNC_PIN 2'h0
`define SLTCS_SYNC_TS 2'h1
`define SLTCS_SYNC_SW 2'h2
// ==========================================
// Character codes
`define SLTCS_K28_7 8'hfc
`define SLTCS_K28_1 8'h3c
`define SLTCS_K28_5 8'hbc
`define SLTCS_D21_5 8'hb5
`endif

// ### src/sltcs_pkg.sv
// Types shared by the link register bank
package sltcs_pkg;
	// ==========================================
	// Test pattern modes
	typedef enum logic [3:0] {
		SLTCS_TP_NORMAL = 4'h0, SLTCS_TP_PRBS7 = 4'h1, SLTCS_TP_PRBS15 = 4'h2,
		SLTCS_TP_PRBS23 = 4'h3, SLTCS_TP_RAMP = 4'h4, SLTCS_TP_TRANSPORT = 4'h5,
		SLTCS_TP_D215 = 4'h6, SLTCS_TP_K285 = 4'h7, SLTCS_TP_ILA = 4'h8,
		SLTCS_TP_RPAT = 4'h9, SLTCS_TP_LOW = 4'ha, SLTCS_TP_HIGH = 4'hb
	} sltcs_tpat_t;
	// ==========================================
	// Control register fields
	typedef struct packed {
		logic [1:0] sync_sel;
		logic sample_format;
		logic scrambler;
	} sltcs_ctrl_t;
	// ==========================================
	// Transmit configuration bundle
	typedef struct packed {
		logic [3:0] mode;
		logic sample_format;
		logic scrambler;
		logic replace_data;
		logic static_low;
		logic static_high;
		logic ila_repeat;
		logic fill_valid;
		logic fill_k;
		logic [7:0] fill_char;
	} sltcs_tx_cfg_t;
	// ==========================================
	// Power and reset bundle
	typedef struct packed {
		logic tx_reset;
		logic serdes_pd;
		logic clk_gate;
		logic mfc_reset;
	} sltcs_pwr_t;
endpackage

// ### src/sltcs_regs.sv
// Control and status register bank of the serial link transmitter
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "sltcs_defs.svh"

module sltcs_regs
	import sltcs_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sync inputs, low while asserted; the timestamp receiver enable is high while on
	input wire logic single_ended_sync_pin_n,
	input wire logic timestamp_diff_input_n,
	input wire logic timestamp_receiver_enable,
	// Link state from the transmit datapath
	input wire logic link_up_in,
	input wire logic pll_locked_in,
	input wire logic realign_event,
	input wire logic multiframe_phase_set_flag_event,
	// Frame monitoring
	input wire logic frame_boundary,
	input wire logic frame_monitor_ok,
	// Configuration to the datapath
	output logic link_sync_request,
	output sltcs_tx_cfg_t tx_cfg,
	output logic [7:0] ila_id_link_a,
	output logic [7:0] ila_id_link_b,
	output logic [7:0] eof_comma_code,
	output logic eof_comma_insert,
	output sltcs_pwr_t pwr
);

	// ==========================================
	// Storage
	logic if_en_r; // Interface enable
	logic sw_sync_r; // Software sync, low requests
	sltcs_ctrl_t ctrl_r; // Link control fields
	logic [3:0] tpat_r; // Test pattern select
	logic [7:0] id_r; // Identifier, bit 0 forced low
	logic [1:0] comma_r; // End-of-frame comma select
	logic realigned_r; // Sticky realign flag
	logic multiframe_phase_set_flag_r; // Sticky align flag
	logic link_up_r; // Sampled link-up
	logic pll_r; // Sampled PLL lock
	logic sync_req_nxt; // Sync request before the flop
	logic [7:0] stat_nxt; // Status read value
	logic [7:0] rdata_nxt; // Read mux
	sltcs_tx_cfg_t cfg_nxt; // Decoded configuration

	// Write strobes per register
	logic wr_if_en;
	logic wr_sw_sync;
	logic wr_ctrl;
	logic wr_tpat;
	logic wr_id;
	logic wr_comma;
	logic wr_stat;

	// ==========================================
	// Address decode
	assign wr_if_en = reg_wr && (reg_addr == `SLTCS_OFS_IF_EN);
	assign wr_sw_sync = reg_wr && (reg_addr == `SLTCS_OFS_SW_SYNC);
	assign wr_ctrl = reg_wr && (reg_addr == `SLTCS_OFS_CTRL);
	assign wr_tpat = reg_wr && (reg_addr == `SLTCS_OFS_TPAT);
	assign wr_id = reg_wr && (reg_addr == `SLTCS_OFS_ID);
	assign wr_comma = reg_wr && (reg_addr == `SLTCS_OFS_COMMA);
	assign wr_stat = reg_wr && (reg_addr == `SLTCS_OFS_STAT);

	// ==========================================
	// Enable and software sync registers
	// Writes are never refused; software is trusted to disable first
	always_ff @(posedge core_clk) begin
		if (reset) begin
			if_en_r <= `SLTCS_RST_IF_EN;
			sw_sync_r <= `SLTCS_RST_SW_SYNC;
		end else begin
			// Enable bit only; upper bits read zero
			if (wr_if_en) begin
				if_en_r <= reg_wdata[0];
			end
			if (wr_sw_sync) begin
				sw_sync_r <= reg_wdata[0];
			end
		end
	end

	// ==========================================
	// Control, pattern, identifier and comma registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_r <= `SLTCS_RST_CTRL;
			tpat_r <= `SLTCS_RST_TPAT;
			id_r <= `SLTCS_RST_ID;
			comma_r <= `SLTCS_RST_COMMA;
		end else begin
			// Format and scrambler resets give signed, scrambler off
			if (wr_ctrl) begin
				ctrl_r <= reg_wdata[3:0];
			end
			if (wr_tpat) begin
				tpat_r <= reg_wdata[3:0];
			end
			// Odd value stored as the even value below
			if (wr_id) begin
				id_r <= {reg_wdata[7:1], 1'b0};
			end
			if (wr_comma) begin
				comma_r <= reg_wdata[1:0];
			end
		end
	end

	// ==========================================
	// Sticky alignment flags
	// A new event beats a clearing write in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			realigned_r <= 1'b0;
			multiframe_phase_set_flag_r <= 1'b0;
		end else begin
			if (realign_event) begin
				realigned_r <= 1'b1;
			end else if (wr_stat && reg_wdata[`SLTCS_ST_REALIGN]) begin
				realigned_r <= 1'b0;
			end
			if (multiframe_phase_set_flag_event) begin
				multiframe_phase_set_flag_r <= 1'b1;
			end else if (wr_stat && reg_wdata[`SLTCS_ST_ALIGN]) begin
				multiframe_phase_set_flag_r <= 1'b0;
			end
		end
	end

	// ==========================================
	// Sampled link state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_up_r <= 1'b0;
			pll_r <= 1'b0;
		end else begin
			link_up_r <= link_up_in;
			pll_r <= pll_locked_in;
		end
	end

	// ==========================================
	// Sync request selection
	// The software bit always requests, whatever the source
	always_comb begin
		sync_req_nxt = !sw_sync_r;
		case (ctrl_r.sync_sel)
			// Single-ended pin
			`SLTCS_SYNC_PIN: begin
				sync_req_nxt = sync_req_nxt || !single_ended_sync_pin_n;
			end
			// Timestamp input, useless unless its receiver is on
			`SLTCS_SYNC_TS: begin
				sync_req_nxt = sync_req_nxt ||
					(timestamp_receiver_enable && !timestamp_diff_input_n);
			end
			// Pins ignored; lets a stuck pin be overridden
			`SLTCS_SYNC_SW: begin
				sync_req_nxt = !sw_sync_r;
			end
			// Reserved code behaves as software only
			default: begin
				sync_req_nxt = !sw_sync_r;
			end
		endcase
	end

	// Registered request
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_sync_request <= 1'b0;
		end else begin
			link_sync_request <= sync_req_nxt;
		end
	end

	// ==========================================
	// Test pattern decode
	always_comb begin
		cfg_nxt = '0;
		cfg_nxt.mode = tpat_r;
		cfg_nxt.sample_format = ctrl_r.sample_format;
		cfg_nxt.scrambler = ctrl_r.scrambler;
		case (tpat_r)
			// Normal samples
			SLTCS_TP_NORMAL: begin
				cfg_nxt.replace_data = 1'b0;
			end
			// Generated sequences take the lanes
			SLTCS_TP_PRBS7, SLTCS_TP_PRBS15, SLTCS_TP_PRBS23: begin
				cfg_nxt.replace_data = 1'b1;
			end
			// Ramp and transport pattern
			SLTCS_TP_RAMP, SLTCS_TP_TRANSPORT: begin
				cfg_nxt.replace_data = 1'b1;
			end
			// Continuous data character
			SLTCS_TP_D215: begin
				cfg_nxt.replace_data = 1'b1;
				cfg_nxt.fill_valid = 1'b1;
				cfg_nxt.fill_char = `SLTCS_D21_5;
			end
			// Continuous control character
			SLTCS_TP_K285: begin
				cfg_nxt.replace_data = 1'b1;
				cfg_nxt.fill_valid = 1'b1;
				cfg_nxt.fill_k = 1'b1;
				cfg_nxt.fill_char = `SLTCS_K28_5;
			end
			// Alignment sequence repeated forever
			SLTCS_TP_ILA: begin
				cfg_nxt.replace_data = 1'b1;
				cfg_nxt.ila_repeat = 1'b1;
			end
			// Modified random pattern
			SLTCS_TP_RPAT: begin
				cfg_nxt.replace_data = 1'b1;
			end
			// Outputs held low
			SLTCS_TP_LOW: begin
				cfg_nxt.replace_data = 1'b1;
				cfg_nxt.static_low = 1'b1;
			end
			// Outputs held high
			SLTCS_TP_HIGH: begin
				cfg_nxt.replace_data = 1'b1;
				cfg_nxt.static_high = 1'b1;
			end
			// Reserved codes fall back to normal data
			default: begin
				cfg_nxt.replace_data = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Configuration outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tx_cfg <= '0;
			ila_id_link_a <= `SLTCS_RST_ID;
			ila_id_link_b <= `SLTCS_RST_ID;
			eof_comma_code <= `SLTCS_K28_7;
		end else begin
			tx_cfg <= cfg_nxt;
			// Second multiframe identifier per link
			ila_id_link_a <= id_r;
			ila_id_link_b <= id_r + 8'h01;
			case (comma_r)
				2'h1: eof_comma_code <= `SLTCS_K28_1;
				2'h2: eof_comma_code <= `SLTCS_K28_5;
				// Compliant default; reserved code kept safe
				default: eof_comma_code <= `SLTCS_K28_7;
			endcase
		end
	end

	// ==========================================
	// Opportunistic comma insertion
	// Only where the monitor allows, not every frame
	always_ff @(posedge core_clk) begin
		if (reset) begin
			eof_comma_insert <= 1'b0;
		end else begin
			eof_comma_insert <= if_en_r && frame_boundary && frame_monitor_ok &&
				!cfg_nxt.replace_data;
		end
	end

	// ==========================================
	// Power and reset hold
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pwr <= '0;
		end else begin
			pwr.tx_reset <= !if_en_r;
			pwr.serdes_pd <= !if_en_r;
			pwr.clk_gate <= !if_en_r;
			pwr.mfc_reset <= !if_en_r;
		end
	end

	// ==========================================
	// Read path
	always_comb begin
		stat_nxt = '0;
		stat_nxt[`SLTCS_ST_LINK] = link_up_r;
		stat_nxt[`SLTCS_ST_SYNC] = !link_sync_request;
		stat_nxt[`SLTCS_ST_REALIGN] = realigned_r;
		stat_nxt[`SLTCS_ST_ALIGN] = multiframe_phase_set_flag_r;
		stat_nxt[`SLTCS_ST_PLL] = pll_r;
		rdata_nxt = 8'h00;
		case (reg_addr)
			`SLTCS_OFS_IF_EN: rdata_nxt = {7'h00, if_en_r};
			`SLTCS_OFS_SW_SYNC: rdata_nxt = {7'h00, sw_sync_r};
			`SLTCS_OFS_CTRL: rdata_nxt = {4'h0, ctrl_r};
			`SLTCS_OFS_TPAT: rdata_nxt = {4'h0, tpat_r};
			`SLTCS_OFS_ID: rdata_nxt = id_r;
			`SLTCS_OFS_COMMA: rdata_nxt = {6'h00, comma_r};
			`SLTCS_OFS_STAT: rdata_nxt = stat_nxt;
			// Unmapped reads return zero
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ==========================================
	// Assertions
	sequence s_wr_id;
		reg_wr && reg_addr == `SLTCS_OFS_ID;
	endsequence

	sequence s_rd_id;
		reg_rd && reg_addr == `SLTCS_OFS_ID && !reg_wr;
	endsequence

	AST_SYNC_PIN: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.sync_sel == `SLTCS_SYNC_PIN && !single_ended_sync_pin_n |=> link_sync_request)
		else $error("pin sync not followed");

	AST_SYNC_TS: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.sync_sel == `SLTCS_SYNC_TS && sw_sync_r |=>
		link_sync_request == $past(timestamp_receiver_enable && !timestamp_diff_input_n))
		else $error("timestamp sync wrong");

	AST_SYNC_SW: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.sync_sel == `SLTCS_SYNC_SW |=> link_sync_request == !$past(sw_sync_r))
		else $error("software-only sync wrong");

	AST_SW_REQ: assert property (@(posedge core_clk) disable iff (reset)
		reg_wr && reg_addr == `SLTCS_OFS_SW_SYNC && !reg_wdata[0] |-> ##2 link_sync_request)
		else $error("software request missed");

	AST_FORMAT: assert property (@(posedge core_clk) disable iff (reset)
		wr_ctrl |-> ##2 tx_cfg.sample_format == $past(reg_wdata[1], 2))
		else $error("sample format not applied");

	AST_SCRAMBLE: assert property (@(posedge core_clk) disable iff (reset)
		wr_ctrl |-> ##2 tx_cfg.scrambler == $past(reg_wdata[0], 2))
		else $error("scrambler enable not applied");

	AST_REPLACE: assert property (@(posedge core_clk) disable iff (reset)
		wr_tpat && reg_wdata[3:0] != 4'h0 && reg_wdata[3:0] < 4'hc |-> ##2 tx_cfg.replace_data)
		else $error("pattern did not replace data");

	AST_STATIC: assert property (@(posedge core_clk) disable iff (reset)
		tx_cfg.mode == 4'ha |-> tx_cfg.static_low && !tx_cfg.static_high && !eof_comma_insert)
		else $error("static low mode wrong");

	AST_ID_LSB: assert property (@(posedge core_clk) disable iff (reset)
		s_wr_id ##1 s_rd_id |=> reg_rdata == {$past(reg_wdata[7:1], 2), 1'b0})
		else $error("identifier bit 0 not cleared");

	AST_ID_B: assert property (@(posedge core_clk) disable iff (reset)
		$past(!reset) |-> ila_id_link_b == ila_id_link_a + 8'h01)
		else $error("link B identifier not plus one");

	AST_COMMA: assert property (@(posedge core_clk) disable iff (reset)
		comma_r == 2'h2 |=> eof_comma_code == `SLTCS_K28_5)
		else $error("comma select wrong");

	AST_STICKY: assert property (@(posedge core_clk) disable iff (reset)
		realign_event && wr_stat && reg_wdata[`SLTCS_ST_REALIGN] |=> realigned_r)
		else $error("realign event lost to clear");

	AST_SYNC_STAT: assert property (@(posedge core_clk) disable iff (reset)
		reg_rd && reg_addr == `SLTCS_OFS_STAT |=> reg_rdata[`SLTCS_ST_SYNC] == !$past(link_sync_request))
		else $error("sync status polarity wrong");

	AST_DISABLE: assert property (@(posedge core_clk) disable iff (reset)
		!if_en_r ##1 !if_en_r |=> pwr.tx_reset && pwr.serdes_pd && pwr.mfc_reset && !eof_comma_insert)
		else $error("disabled link not held");

endmodule

// ### verif/sltcs_rx_model.sv
// Far-side receiver model: sync request lines and frame marks
`timescale 1ns/1ns
module sltcs_rx_model (
	// Clock
	input wire logic core_clk,
	// Commands from the bench
	input wire logic pin_req,
	input wire logic ts_req,
	input wire logic frame_en,
	// Lines towards the transmitter
	output logic sync_pin_n,
	output logic ts_n,
	output logic frame_boundary,
	output logic frame_monitor_ok
);
	// ==========================================
	// State
	logic [2:0] pos_r; // Cycle within a five-cycle frame
	logic par_r; // Alternates frames with good and bad monitoring

	// ==========================================
	// Sync lines, low while a resync is wanted
	always_ff @(posedge core_clk) begin
		sync_pin_n <= !pin_req;
		ts_n <= !ts_req;
	end

	// ==========================================
	// Frame counter; cleared outside traffic
	always_ff @(posedge core_clk) begin
		if (!frame_en) begin
			pos_r <= 3'h0;
			par_r <= 1'b0;
		end else begin
			pos_r <= (pos_r == 3'h4) ? 3'h0 : pos_r + 3'h1;
			par_r <= (pos_r == 3'h4) ? !par_r : par_r;
		end
	end

	// Idle lines sit low, so no stale mark can leak out between frames
	assign frame_boundary = frame_en && (pos_r == 3'h4);
	assign frame_monitor_ok = frame_en && par_r;
endmodule

// ### verif/tb_serial_link_tx_control_status.sv
// Self-checking bench for the link control and status registers
`timescale 1ns/1ns
module tb_serial_link_tx_control_status
	import sltcs_pkg::*;
;
	// ==========================================
	// Design signals
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, id_a, id_b, comma_code;
	logic reg_wr, reg_rd, ts_en, link_up, pll, realign_ev, align_ev, sync_req, comma_ins;
	logic pin_req, ts_req, frame_en, sync_pin_n, ts_n, fb, fok;
	sltcs_tx_cfg_t tx_cfg;
	sltcs_pwr_t pwr;
	// ==========================================
	// Bench state
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	logic rd_seen = 1'b0; // Read taken at the last edge
	logic fb_seen = 1'b0; // Good boundary seen at the last edge
	logic ins_chk = 1'b0; // Insert pulses under watch
	logic ins_on = 1'b0; // Insertion currently allowed
	int fail_count = 0;
	int check_count = 0;
	int cycle_cnt = 0;
	integer seed = 32'h67bd_2a60;
	logic [7:0] v, e;
	logic s_req;

	// Clock, 40 ns period
	always #20 core_clk = ~core_clk;

	// ==========================================
	// Design and far-side model
	sltcs_regs u_sltcs_regs (
		.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.single_ended_sync_pin_n(sync_pin_n), .timestamp_diff_input_n(ts_n),
		.timestamp_receiver_enable(ts_en), .link_up_in(link_up), .pll_locked_in(pll),
		.realign_event(realign_ev), .multiframe_phase_set_flag_event(align_ev), .frame_boundary(fb),
		.frame_monitor_ok(fok), .link_sync_request(sync_req), .tx_cfg(tx_cfg),
		.ila_id_link_a(id_a), .ila_id_link_b(id_b), .eof_comma_code(comma_code),
		.eof_comma_insert(comma_ins), .pwr(pwr)
	);
	sltcs_rx_model u_sltcs_rx_model (
		.core_clk(core_clk), .pin_req(pin_req), .ts_req(ts_req), .frame_en(frame_en),
		.sync_pin_n(sync_pin_n), .ts_n(ts_n), .frame_boundary(fb), .frame_monitor_ok(fok)
	);

	// ==========================================
	// Compare, report and bus tasks
	task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Read results are paired with the oldest note
	task automatic cmp_rd(input logic [7:0] got);
		cmp_out(got, exp_q.pop_front());
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle read strobe; expectation noted first
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		@(posedge core_clk);
		exp_q.push_back(x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	// Room for the register stage and the output stage to land
	// Ends on an edge, so stimulus that follows still lands by NBA at that edge
	task automatic settle;
		repeat (4) @(posedge core_clk);
	endtask

	// ==========================================
	// Output watcher; values read here are those before this edge
	always @(posedge core_clk) begin
		if (rd_seen) begin
			cmp_rd(reg_rdata);
		end else if (!reset) begin
			cmp_out(reg_rdata, 8'h00);
		end
		if (ins_chk) begin
			cmp_out({7'h0, comma_ins}, {7'h0, fb_seen & ins_on});
		end
		rd_seen <= reg_rd;
		fb_seen <= fb & fok;
		cycle_cnt++;
		// Hang guard, generous over the expected run of under a thousand cycles
		if (cycle_cnt > 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		{reg_wr, reg_rd, ts_en, realign_ev, align_ev, pin_req, ts_req, frame_en} = 8'h00;
		{link_up, pll} = 2'b11;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		// Reset values, reserved and unmapped places
		rd(12'h200, 8'h01);
		rd(12'h203, 8'h01);
		rd(12'h204, 8'h02);
		rd(12'h205, 8'h00);
		rd(12'h206, 8'h00);
		rd(12'h207, 8'h00);
		rd(12'h208, 8'h64);
		rd(12'h209, 8'h00);
		cmp_out(comma_code, 8'hfc);
		cmp_out({4'h0, pwr}, 8'h00);
		// Disable before any setting changes
		wr(12'h200, 8'h00);
		settle();
		cmp_out({4'h0, pwr}, 8'h0f);
		// Format and scrambler bits, reserved bits set on write
		for (int i = 0; i < 4; i++) begin
			wr(12'h204, {6'h3c, 2'(i)});
			settle();
			cmp_out({7'h0, tx_cfg.sample_format}, {7'h0, i[1]});
			cmp_out({7'h0, tx_cfg.scrambler}, {7'h0, i[0]});
			rd(12'h204, {6'h00, 2'(i)});
		end
		// Every test pattern code, reserved ones included
		for (int t = 0; t < 16; t++) begin
			wr(12'h205, {4'ha, 4'(t)});
			settle();
			if (t < 12) cmp_out({4'h0, tx_cfg.mode}, 8'(t));
			cmp_out({7'h0, tx_cfg.replace_data}, {7'h0, t > 0 && t < 12});
			cmp_out({7'h0, tx_cfg.ila_repeat}, {7'h0, t == 8});
			cmp_out({7'h0, tx_cfg.static_low}, {7'h0, t == 10});
			cmp_out({7'h0, tx_cfg.static_high}, {7'h0, t == 11});
			if (t == 6) cmp_out(tx_cfg.fill_char, 8'hb5);
			if (t == 7) cmp_out(tx_cfg.fill_char, 8'hbc);
			cmp_out({6'h0, tx_cfg.fill_valid, tx_cfg.fill_k}, {6'h0, t == 6 || t == 7, t == 7});
			rd(12'h205, 8'(t));
		end
		wr(12'h205, 8'h00);
		// Identifier: odd edge values, then random ones
		for (int n = 0; n < 5; n++) begin
			v = (n == 0) ? 8'hff : (n == 1) ? 8'h01 : 8'($random(seed));
			e = v & 8'hfe;
			wr(12'h206, v);
			settle();
			cmp_out(id_a, e);
			cmp_out(id_b, e + 8'h01);
			rd(12'h206, e);
		end
		// Odd write followed at once by its read, no gap between strobes
		@(posedge core_clk);
		reg_addr <= 12'h206;
		reg_wdata <= 8'h5b;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		exp_q.push_back(8'h5a);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// End-of-frame comma codes
		for (int c = 0; c < 4; c++) begin
			wr(12'h207, {6'h3f, 2'(c)});
			settle();
			cmp_out(comma_code, (c == 1) ? 8'h3c : (c == 2) ? 8'hbc : 8'hfc);
			rd(12'h207, 8'(c));
		end
		wr(12'h207, 8'h00);
		// Sync source against pin, timestamp and its receiver enable
		for (int s = 0; s < 4; s++) begin
			wr(12'h204, {4'h0, 2'(s), 2'b10});
			for (int k = 0; k < 8; k++) begin
				@(posedge core_clk);
				pin_req <= k[0];
				ts_req <= k[1];
				ts_en <= k[2];
				settle();
				s_req = (s == 0 && k[0]) || (s == 1 && k[1] && k[2]);
				cmp_out({7'h0, sync_req}, {7'h0, s_req});
				rd(12'h208, {2'b01, !s_req, 5'b00100});
			end
		end
		pin_req <= 1'b0;
		ts_req <= 1'b0;
		// Software request with pins ignored
		wr(12'h203, 8'h00);
		settle();
		cmp_out({7'h0, sync_req}, 8'h01);
		wr(12'h203, 8'h01);
		settle();
		cmp_out({7'h0, sync_req}, 8'h00);
		// Sticky flags, write-one clear, event beating a clear
		realign_ev <= 1'b1;
		align_ev <= 1'b1;
		@(posedge core_clk);
		realign_ev <= 1'b0;
		align_ev <= 1'b0;
		rd(12'h208, 8'h7c);
		wr(12'h208, 8'h10);
		rd(12'h208, 8'h6c);
		@(posedge core_clk);
		reg_addr <= 12'h208;
		reg_wdata <= 8'h18;
		reg_wr <= 1'b1;
		realign_ev <= 1'b1;
		align_ev <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		realign_ev <= 1'b0;
		align_ev <= 1'b0;
		rd(12'h208, 8'h7c);
		wr(12'h208, 8'hff);
		link_up <= 1'b0;
		pll <= 1'b0;
		rd(12'h208, 8'h20);
		// Enabled with normal data: commas follow good boundaries
		wr(12'h200, 8'h01);
		settle();
		cmp_out({4'h0, pwr}, 8'h00);
		frame_en <= 1'b1;
		ins_on <= 1'b1;
		ins_chk <= 1'b1;
		repeat (40) @(posedge core_clk);
		ins_chk <= 1'b0;
		// A test pattern keeps commas out
		wr(12'h200, 8'h00);
		wr(12'h205, 8'h05);
		wr(12'h200, 8'h01);
		settle();
		ins_on <= 1'b0;
		ins_chk <= 1'b1;
		repeat (40) @(posedge core_clk);
		ins_chk <= 1'b0;
		repeat (4) @(posedge core_clk);
		give_verdict();
	end
endmodule
